// ---- rtl/csc_cfg.svh ----
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_ADDR_CTL0 32'h0FFF_FD00
`define CSC_ADDR_CTL1 32'h0FFF_FD04
`define CSC_ADDR_LEN 32'h0FFF_FD08
`define CSC_ADDR_STAT 32'h0FFF_FD0C
`define CSC_ADDR_TX 32'h0FFF_FD10
`define CSC_ADDR_RX 32'h0FFF_FD14
`define CSC_CTL0_RST 8'h01
`define CSC_CTL1_RST 8'h00
`define CSC_LEN_RST 4'h0
`define CSC_CTL0_WMASK 8'hF3
`define CSC_CTL0_LIVE 8'h81
`define CSC_CTL1_WMASK 8'h1F
`define CSC_B_PWR 7
`define CSC_B_TXE 6
`define CSC_B_RXE 5
`define CSC_B_DIR 4
`define CSC_B_TMS 1
`define CSC_B_SCE 0
`define CSC_B_CKP 4
`define CSC_B_DAP 3
`define CSC_B_TSF 7
`define CSC_B_OVE 0
`define CSC_CKS_BRG 3'h6
`define CSC_CKS_EXT 3'h7
`define CSC_MIN_LEN 5'h08
`define CSC_MAX_LEN 5'h10
`endif

// ---- rtl/csc_pkg.sv ----
`default_nettype none
package csc_pkg;
    typedef enum {CSC_IDLE, CSC_RUN} csc_state_e;
    typedef logic [15:0] csc_word_t;
    typedef logic [4:0] csc_len_t;
endpackage
`default_nettype wire

// ---- rtl/csc_shift_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface csc_shift_if;
    import csc_pkg::*;
    logic clr, start, txe, lsb_first, dap, sin, lead, trail, more, done, sout;
    csc_len_t len;
    csc_word_t tx_data, rx_data;
    modport ctl(output clr, start, txe, lsb_first, dap, len, tx_data, sin,
        input done, rx_data, sout, more);
    modport eng(input clr, start, txe, lsb_first, dap, len, tx_data, sin, lead, trail,
        output done, rx_data, sout, more);
    modport clk(input more, output lead, trail);
endinterface
`default_nettype wire

// ---- rtl/csc_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
module csc_shifter
    import csc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    csc_shift_if.eng sif
);
    csc_word_t sr, next_sr, rx, next_rx, mask;
    logic [4:0] cnt, next_cnt;
    logic busy, next_busy, done, next_done, sout, next_sout;
    logic ob, fin, out_ev, smp_ev;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_mask
            assign mask[i] = (5'(i) < sif.len);
        end
    endgenerate

    always_comb begin
        next_sr = sr;
        next_rx = rx;
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_sout = sout;
        fin = 1'b0;
        ob = sif.lsb_first ? sr[0] : sr[4'(sif.len - 5'h01)];
        out_ev = sif.dap ? sif.trail : sif.lead;
        smp_ev = sif.dap ? sif.lead : sif.trail;
        if (sif.clr) begin
            next_busy = 1'b0;
            next_cnt = 5'h00;
            next_sout = 1'b0;
        end else if (!busy) begin
            if (sif.start) begin
                next_sr = sif.tx_data;
                next_cnt = 5'h00;
                next_busy = 1'b1;
                if (sif.dap) begin
                    next_sout = sif.lsb_first ? sif.tx_data[0]
                                              : sif.tx_data[4'(sif.len - 5'h01)];
                end
            end
        end else begin
            if (out_ev) begin
                next_sout = ob;
            end
            if (smp_ev) begin
                next_cnt = cnt + 5'h01;
                if (sif.lsb_first) begin
                    next_sr = sr >> 1;
                    next_sr[4'(sif.len - 5'h01)] = sif.sin;
                end else begin
                    next_sr = {sr[14:0], sif.sin};
                end
            end
            if (sif.trail && next_cnt == sif.len) begin
                fin = 1'b1;
                next_done = 1'b1;
                next_busy = 1'b0;
                next_sout = 1'b0;
                next_rx = next_sr & mask;
            end
        end
        if (!sif.txe) begin
            next_sout = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr <= 16'h0000;
            rx <= 16'h0000;
            cnt <= 5'h00;
            busy <= 1'b0;
            done <= 1'b0;
            sout <= 1'b0;
        end else begin
            sr <= next_sr;
            rx <= next_rx;
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
            sout <= next_sout;
        end
    end

    assign sif.more = busy & ~fin & ~sif.clr;
    assign sif.done = done;
    assign sif.rx_data = rx;
    assign sif.sout = sout;
endmodule
`default_nettype wire

// ---- rtl/csc_clkgen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
module csc_clkgen
    import csc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ckp,
    input wire logic [2:0] cks,
    input wire logic baud_tick,
    input wire logic sck_in,
    output logic sck_out,
    csc_shift_if.clk sif
);
    logic [5:0] div, next_div, lim;
    logic [2:0] sync, next_sync;
    logic sck, next_sck, lead, next_lead, trail, next_trail, tick, idle;

    always_comb begin
        idle = ~ckp;
        lim = (6'h01 << cks) - 6'h01;
        tick = (cks == `CSC_CKS_BRG) ? baud_tick : (div == lim);
        next_sync = {sync[1], sync[0], sck_in};
        next_div = 6'h00;
        next_sck = idle;
        next_lead = 1'b0;
        next_trail = 1'b0;
        if (sif.more) begin
            if (cks == `CSC_CKS_EXT) begin
                if (sync[1] != sync[2]) begin
                    next_lead = (sync[2] == idle);
                    next_trail = (sync[2] != idle);
                end
            end else begin
                next_div = tick ? 6'h00 : div + 6'h01;
                next_sck = tick ? ~sck : sck;
                next_lead = tick && (sck == idle);
                next_trail = tick && (sck != idle);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 6'h00;
            sync <= 3'h7;
            sck <= 1'b1;
            lead <= 1'b0;
            trail <= 1'b0;
        end else begin
            div <= next_div;
            sync <= next_sync;
            sck <= next_sck;
            lead <= next_lead;
            trail <= next_trail;
        end
    end

    assign sck_out = sck;
    assign sif.lead = lead;
    assign sif.trail = trail;
endmodule
`default_nettype wire

// ---- rtl/csc_serial_ctrl.sv ----
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"

module csc_serial_ctrl
    import csc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic baud_tick,
    input wire logic serial_in_pin,
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    output logic serial_out_pin,
    output logic rx_complete_irq,
    output logic tx_ready_irq
);
    csc_shift_if sif();

    logic [7:0] ctl0, next_ctl0, ctl1, next_ctl1;
    logic [3:0] len_reg, next_len;
    csc_word_t tx_buf, next_tx_buf, rx_buf, next_rx_buf;
    logic tx_full, next_tx_full, rx_full, next_rx_full, ovr, next_ovr;
    csc_state_e state, next_state;
    logic start_r, next_start, next_rx_irq, next_tx_irq, next_sck_oe;
    logic wr_pend, next_wr_pend;
    logic [31:0] wr_addr, next_wr_addr, next_hrdata;
    logic sin_meta, sin_sync;
    logic acc, rd_rx, wr_ctl0, wr_ctl1, wr_len, wr_stat, wr_tx, can_start, pwr_drop;
    logic pwr, txe, rxe, tms, sce;

    assign pwr = ctl0[`CSC_B_PWR];
    assign txe = ctl0[`CSC_B_TXE];
    assign rxe = ctl0[`CSC_B_RXE];
    assign tms = ctl0[`CSC_B_TMS];
    assign sce = ctl0[`CSC_B_SCE];

    // ahb-lite slave, zero wait states
    assign acc = hsel && htrans[1] && hready;
    assign rd_rx = acc && !hwrite && haddr == `CSC_ADDR_RX;
    assign wr_ctl0 = wr_pend && wr_addr == `CSC_ADDR_CTL0;
    assign wr_ctl1 = wr_pend && wr_addr == `CSC_ADDR_CTL1;
    assign wr_len = wr_pend && wr_addr == `CSC_ADDR_LEN;
    assign wr_stat = wr_pend && wr_addr == `CSC_ADDR_STAT;
    assign wr_tx = wr_pend && wr_addr == `CSC_ADDR_TX;

    always_comb begin
        next_wr_pend = acc && hwrite;
        next_wr_addr = (acc && hwrite) ? haddr : wr_addr;
        next_hrdata = 32'h0000_0000;
        if (acc && !hwrite) begin
            unique case (haddr)
                `CSC_ADDR_CTL0: next_hrdata = {24'h00_0000, ctl0};
                `CSC_ADDR_CTL1: next_hrdata = {24'h00_0000, ctl1};
                `CSC_ADDR_LEN: next_hrdata = {28'h000_0000, len_reg};
                `CSC_ADDR_STAT: next_hrdata = {24'h00_0000, state == CSC_RUN, 6'h00, ovr};
                `CSC_ADDR_TX: next_hrdata = {16'h0000, tx_buf};
                `CSC_ADDR_RX: next_hrdata = {16'h0000, rx_buf};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // serial data input synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
        end else begin
            sin_meta <= serial_in_pin;
            sin_sync <= sin_meta;
        end
    end

    // control registers and transfer sequencing
    always_comb begin
        next_ctl0 = ctl0;
        next_ctl1 = ctl1;
        next_len = len_reg;
        next_tx_buf = tx_buf;
        next_tx_full = tx_full;
        next_rx_buf = rx_buf;
        next_rx_full = rx_full;
        next_ovr = ovr;
        next_state = state;
        next_start = 1'b0;
        next_rx_irq = 1'b0;
        next_tx_irq = 1'b0;
        next_sck_oe = pwr && ctl1[2:0] != `CSC_CKS_EXT;
        can_start = pwr && (state == CSC_IDLE || sif.done);
        if (wr_ctl0) begin
            if (pwr) begin
                next_ctl0 = (ctl0 & ~`CSC_CTL0_LIVE) | (hwdata[7:0] & `CSC_CTL0_LIVE);
            end else begin
                next_ctl0 = hwdata[7:0] & `CSC_CTL0_WMASK;
            end
        end
        if (wr_ctl1 && !pwr) begin
            next_ctl1 = hwdata[7:0] & `CSC_CTL1_WMASK;
        end
        if (wr_len && (!pwr || !(txe || rxe))) begin
            next_len = hwdata[3:0];
        end
        if (wr_tx) begin
            next_tx_buf = hwdata[15:0];
        end
        if (rd_rx) begin
            next_rx_full = 1'b0;
        end
        if (wr_stat && !hwdata[`CSC_B_OVE]) begin
            next_ovr = 1'b0;
        end
        if (sif.done) begin
            next_state = CSC_IDLE;
            if (rxe) begin
                next_rx_buf = sif.rx_data;
                next_rx_full = 1'b1;
                if (rx_full) begin
                    next_ovr = 1'b1;
                end
            end
            next_rx_irq = rxe || !tms;
        end
        if (can_start) begin
            if (txe && tms && tx_full) begin
                next_start = 1'b1;
                next_tx_full = 1'b0;
                next_tx_irq = 1'b1;
            end else if (txe && !tms && wr_tx) begin
                next_start = 1'b1;
            end else if (!txe && rxe && sce && (rd_rx || (tms && sif.done))) begin
                next_start = 1'b1;
            end
        end
        if (wr_tx && txe && tms) begin
            next_tx_full = 1'b1;
        end
        if (next_start) begin
            next_state = CSC_RUN;
        end
        pwr_drop = !next_ctl0[`CSC_B_PWR];
        if (pwr_drop) begin
            next_state = CSC_IDLE;
            next_start = 1'b0;
            next_tx_full = 1'b0;
            next_rx_full = 1'b0;
            next_rx_buf = 16'h0000;
            next_ovr = 1'b0;
            next_rx_irq = 1'b0;
            next_tx_irq = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl0 <= `CSC_CTL0_RST;
            ctl1 <= `CSC_CTL1_RST;
            len_reg <= `CSC_LEN_RST;
            tx_buf <= 16'h0000;
            tx_full <= 1'b0;
            rx_buf <= 16'h0000;
            rx_full <= 1'b0;
            ovr <= 1'b0;
            state <= CSC_IDLE;
            start_r <= 1'b0;
            rx_complete_irq <= 1'b0;
            tx_ready_irq <= 1'b0;
            serial_clock_oe <= 1'b0;
        end else begin
            ctl0 <= next_ctl0;
            ctl1 <= next_ctl1;
            len_reg <= next_len;
            tx_buf <= next_tx_buf;
            tx_full <= next_tx_full;
            rx_buf <= next_rx_buf;
            rx_full <= next_rx_full;
            ovr <= next_ovr;
            state <= next_state;
            start_r <= next_start;
            rx_complete_irq <= next_rx_irq;
            tx_ready_irq <= next_tx_irq;
            serial_clock_oe <= next_sck_oe;
        end
    end

    assign sif.clr = !pwr;
    assign sif.start = start_r;
    assign sif.txe = txe;
    assign sif.lsb_first = ctl0[`CSC_B_DIR];
    assign sif.dap = ctl1[`CSC_B_DAP];
    assign sif.len = len_reg[3] ? `CSC_MAX_LEN : `CSC_MIN_LEN + {2'b00, len_reg[2:0]};
    assign sif.tx_data = tx_buf;
    assign sif.sin = sin_sync;
    assign serial_out_pin = sif.sout;

    csc_shifter u_shifter (
        .hclk(hclk),
        .hresetn(hresetn),
        .sif(sif)
    );

    csc_clkgen u_clkgen (
        .hclk(hclk),
        .hresetn(hresetn),
        .ckp(ctl1[`CSC_B_CKP]),
        .cks(ctl1[2:0]),
        .baud_tick(baud_tick),
        .sck_in(serial_clock_in),
        .sck_out(serial_clock_out),
        .sif(sif)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pwr_off_clear: assert property (
        !pwr |-> !ovr && !rx_full && state == CSC_IDLE && rx_buf == 16'h0000)
        else $error("unpowered channel kept state");
    a_abort_clock: assert property (
        !pwr |=> !sif.more && !start_r && serial_clock_out == !$past(ctl1[`CSC_B_CKP]))
        else $error("serial clock still running while unpowered");
    a_txe_low_out: assert property (
        !txe |=> !serial_out_pin)
        else $error("data output not low with transmit disabled");
    a_rx_frozen: assert property (
        pwr && !rxe ##1 pwr |-> $stable(rx_buf) && !(rx_complete_irq && tms))
        else $error("receive buffer moved with receive disabled");
    a_mode_locked: assert property (
        $past(pwr) |-> ctl0[6:1] == $past(ctl0[6:1]))
        else $error("mode bits changed while powered");
    a_clk_cfg_locked: assert property (
        $past(pwr) |-> $stable(ctl1))
        else $error("clock config changed while powered");
    a_single_irq: assert property (
        pwr && !tms && sif.done && !pwr_drop |=> rx_complete_irq && !tx_ready_irq)
        else $error("single mode interrupt wrong");
    a_busy_no_start: assert property (
        state == CSC_RUN && !sif.done |=> !start_r)
        else $error("transfer started while busy");
    a_overrun_set: assert property (
        pwr && rxe && rx_full && sif.done && !pwr_drop |=> ovr && rx_complete_irq)
        else $error("overrun not flagged");
    a_rx_auto: assert property (
        pwr && !txe && rxe && tms && sce && sif.done && !pwr_drop
        |=> start_r && state == CSC_RUN ##1 sif.more)
        else $error("continuous receive did not restart");
    a_trigger_gate: assert property (
        !sce && !txe && rd_rx |=> !start_r)
        else $error("receive started with trigger disabled");
    a_single_rx_trig: assert property (
        pwr && !txe && rxe && !tms && sce && rd_rx && state == CSC_IDLE && !pwr_drop
        |=> start_r && state == CSC_RUN)
        else $error("single receive read did not start a transfer");
    a_tx_ignore_trig: assert property (
        pwr && txe && !tms && !sce && wr_tx && state == CSC_IDLE && !pwr_drop |=> start_r)
        else $error("transmit start blocked by trigger enable");
    a_len_range: assert property (
        sif.len >= `CSC_MIN_LEN && sif.len <= `CSC_MAX_LEN)
        else $error("transfer length out of range");
    a_clk_dir: assert property (
        pwr && ctl1[2:0] == `CSC_CKS_EXT |=> !serial_clock_oe)
        else $error("clock pin driven in slave mode");

    c_single_done: cover property (sif.done && !tms);
    c_rx_cont: cover property (sif.done && tms && !txe && sce);
    c_tx_ready: cover property (tx_ready_irq);
    c_overrun: cover property ($rose(ovr));
endmodule
`default_nettype wire

// ---- verif/csc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module csc_peer
    import csc_pkg::*;
(
    input wire logic sck,
    input wire logic sout,
    output logic sin,
    output logic sck_drv
);
    csc_word_t pword;
    csc_word_t got;
    int nbit;
    initial begin
        sin = 1'b0;
        sck_drv = 1'b1;
        pword = 16'h0000;
        got = 16'h0000;
        nbit = 0;
    end
    // type 1 peer: next bit out on the falling edge
    always @(negedge sck) begin
        sin <= pword[7 - (nbit % 8)];
    end
    // sample on the rising edge; invert the data line 100 ns after every eighth bit
    always @(posedge sck) begin
        got <= {got[14:0], sout};
        nbit <= nbit + 1;
        if (nbit % 8 == 7) begin
            sin <= #100 ~sin;
        end
    end
    // slave-mode clock, only within a frame, idle high
    task automatic frame(input int n);
        #7;
        repeat (n) begin
            #200 sck_drv = 1'b0;
            #200 sck_drv = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_clocked_serial_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
`define CHK(nm, exp, got) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb_clocked_serial_control
    import csc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [1:0] bcnt = 2'b00;
    logic baud_tick = 1'b0;
    logic hreadyout, hresp, sin, sout, sck_o, sck_oe, sck_p, rx_irq, tx_irq;
    logic tx_off = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_rxi = 0;
    int n_txr = 0;
    int snap;
    wire logic sck = sck_oe ? sck_o : sck_p;

    csc_serial_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .baud_tick(baud_tick), .serial_in_pin(sin), .serial_clock_in(sck),
        .serial_clock_out(sck_o), .serial_clock_oe(sck_oe), .serial_out_pin(sout),
        .rx_complete_irq(rx_irq), .tx_ready_irq(tx_irq));
    csc_peer peer_u (.sck(sck), .sout(sout), .sin(sin), .sck_drv(sck_p));

    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        bcnt <= bcnt + 2'd1;
        baud_tick <= (bcnt == 2'd3);
        if (rx_irq === 1'b1) n_rxi++;
        if (tx_irq === 1'b1) n_txr++;
        if (tx_off) `CHK("sout_low", 1'b0, sout)
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string nm);
        ahb(1'b0, a, 32'h0000_0000);
        `CHK(nm, exp, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask

    // power off, set clocking, power on with modes, realign the peer
    task automatic arm(input logic [31:0] c1, input logic [31:0] c0);
        wr(`CSC_ADDR_CTL0, 32'h0000_0000);
        wr(`CSC_ADDR_CTL1, c1);
        wr(`CSC_ADDR_CTL0, c0);
        peer_u.nbit = 0;
    endtask

    task automatic wait_irq();
        int i;
        i = 0;
        while (rx_irq !== 1'b1 && i < 3000) begin
            @(posedge hclk);
            i++;
        end
        `CHK("rx_irq", 1'b1, rx_irq)
        @(posedge hclk);
    endtask

    task automatic wait_idle();
        int i;
        i = 0;
        do begin
            ahb(1'b0, `CSC_ADDR_STAT, 32'h0000_0000);
            i++;
        end while (rd[7] !== 1'b0 && i < 500);
        `CHK("busy_end", 1'b0, rd[7])
    endtask

    initial begin
        #2_000_000;
        `CHK("watchdog", 1'b1, 1'b0)
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`CSC_ADDR_CTL0, 32'h0000_0001, "ctl0_rst");
        rchk(`CSC_ADDR_CTL1, 32'h0000_0000, "ctl1_rst");
        rchk(`CSC_ADDR_STAT, 32'h0000_0000, "stat_rst");
        rchk(32'h0FFF_FD20, 32'h0000_0000, "unmapped");
        wr(`CSC_ADDR_CTL0, 32'h0000_00E1);
        wr(`CSC_ADDR_CTL0, 32'h0000_0091);
        rchk(`CSC_ADDR_CTL0, 32'h0000_00E1, "ctl0_lock");
        wr(`CSC_ADDR_CTL1, 32'h0000_0005);
        rchk(`CSC_ADDR_CTL1, 32'h0000_0000, "ctl1_lock");
        `CHK("sck_idle0", 1'b1, sck_o)
        snap = n_rxi;
        for (int c = 1; c < 7; c++) begin
            arm(32'(c), 32'h0000_00E1);
            peer_u.pword = 16'h00C0 + 16'(c);
            wr(`CSC_ADDR_TX, 32'h0000_005A + 32'(c));
            rchk(`CSC_ADDR_STAT, 32'h0000_0080, "busy");
            wr(`CSC_ADDR_TX, 32'h0000_00FF);
            wait_irq();
            rchk(`CSC_ADDR_STAT, 32'h0000_0000, "no_restart");
            if (c > 1) rchk(`CSC_ADDR_RX, 32'h0000_00C0 + 32'(c), "rx_data");
            `CHK("peer_got", 8'h5A + 8'(c), peer_u.got[7:0])
        end
        `CHK("rx_irq_cnt", snap + 6, n_rxi)
        arm(32'h0000_0002, 32'h0000_00F0);
        peer_u.pword = 16'h0001;
        wr(`CSC_ADDR_TX, 32'h0000_0001);
        wait_irq();
        `CHK("lsb_tx", 8'h80, peer_u.got[7:0])
        rchk(`CSC_ADDR_RX, 32'h0000_0080, "lsb_rx");
        `CHK("no_txirq", 0, n_txr)
        arm(32'h0000_0002, 32'h0000_00C2);
        snap = n_rxi;
        wr(`CSC_ADDR_TX, 32'h0000_0012);
        wr(`CSC_ADDR_TX, 32'h0000_0034);
        wait_idle();
        `CHK("cont_tx", 16'h1234, peer_u.got[15:0])
        `CHK("txirq_cnt", 2, n_txr)
        `CHK("rxirq_off", snap, n_rxi)
        tx_off = 1'b1;
        arm(32'h0000_0002, 32'h0000_00A0);
        rchk(`CSC_ADDR_RX, 32'h0000_0000, "rx_dummy");
        rchk(`CSC_ADDR_STAT, 32'h0000_0000, "trig_off");
        arm(32'h0000_0002, 32'h0000_00A1);
        peer_u.pword = 16'h005C;
        rchk(`CSC_ADDR_RX, 32'h0000_0000, "srx_dummy");
        wait_irq();
        rchk(`CSC_ADDR_STAT, 32'h0000_0000, "srx_stop");
        wr(`CSC_ADDR_CTL0, 32'h0000_00A0);
        rchk(`CSC_ADDR_RX, 32'h0000_005C, "srx_last");
        rchk(`CSC_ADDR_STAT, 32'h0000_0000, "srx_no_more");
        arm(32'h0000_0002, 32'h0000_00A3);
        peer_u.pword = 16'h0066;
        rchk(`CSC_ADDR_RX, 32'h0000_0000, "rx_start");
        wait_irq();
        wait_irq();
        ahb(1'b0, `CSC_ADDR_STAT, 32'h0000_0000);
        `CHK("overrun", 1'b1, rd[0])
        wr(`CSC_ADDR_CTL0, 32'h0000_00A2);
        wait_irq();
        wait_idle();
        rchk(`CSC_ADDR_RX, 32'h0000_0066, "rx_last");
        tx_off = 1'b0;
        arm(32'h0000_0005, 32'h0000_00C1);
        snap = n_rxi;
        wr(`CSC_ADDR_TX, 32'h0000_00AA);
        repeat (100) @(posedge hclk);
        wr(`CSC_ADDR_CTL0, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        `CHK("abort_oe", 1'b0, sck_oe)
        repeat (600) @(posedge hclk);
        `CHK("abort_irq", snap, n_rxi)
        rchk(`CSC_ADDR_STAT, 32'h0000_0000, "stat_off");
        arm(32'h0000_0010, 32'h0000_0081);
        repeat (3) @(posedge hclk);
        `CHK("sck_idle1", 1'b0, sck_o)
        arm(32'h0000_0007, 32'h0000_00C1);
        `CHK("slave_oe", 1'b0, sck_oe)
        wr(`CSC_ADDR_TX, 32'h0000_0096);
        peer_u.frame(8);
        wait_irq();
        `CHK("slave_tx", 8'h96, peer_u.got[7:0])
        wrap_up();
    end
endmodule
`default_nettype wire
